// ==== logic/ics_pkg.sv ====
// constants and types shared by the collision-checked bus sequencer
package ics_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RELOAD  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_STOP_BIT    = 1;
  localparam int STAT_COLL_BIT    = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_DONE_BIT    = 2;
  localparam int STAT_FREE_BIT    = 3;
  localparam int COUNT_WIDTH      = 7;

  // ----------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] RELOAD_RESET = 8'h04;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // ----------------------------------------------------------------
  // link-side sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ICS_IDLE        = 4'h0,
    ICS_RS_REL_DATA = 4'h1,
    ICS_RS_COUNT1   = 4'h2,
    ICS_RS_CLK_WAIT = 4'h3,
    ICS_RS_COUNT2   = 4'h4,
    ICS_RS_COUNT3   = 4'h5,
    ICS_SP_DATA_LOW = 4'h6,
    ICS_SP_CLK_WAIT = 4'h7,
    ICS_SP_COUNT1   = 4'h8,
    ICS_SP_COUNT2   = 4'h9
  } ics_state_e;

endpackage

// ==== logic/ics_sync.sv ====
// two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
module ics_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== logic/ics_top.sv ====
// restart/stop sequencer with bus collision detection behind an axi4-lite slave
//
// Summary of operation
// - restart: data high, count, release clock, sample
// - restart: data low at clock high, collision
// - restart: clock high, recount; data fall allowed
// - restart: clock falls early, data undriven, collision
// - restart: clock still high at end, drive data
// - restart: second count ends, clock low, done
// - stop: data low, release clock, then count
// - stop: data low after timeout, collision
// - stop: clock low before data high, collision
// - collision sets flag, port returns idle
// - collision aborts sequence, releases lines, clears enable
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ics_top #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_WIDTH-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  link_clk,
  input  wire logic                  serial_clock_line_i,
  output logic                       serial_clock_line_o,
  output logic                       serial_clock_line_oe,
  input  wire logic                  serial_data_line_i,
  output logic                       serial_data_line_o,
  output logic                       serial_data_line_oe
);
  import ics_pkg::*;

  // ----------------------------------------------------------------
  // register side state (aclk)
  // ----------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [31:0]           wr_data;
  logic                  wr_lane0;
  logic [7:0]            baud_reload_register;
  logic                  restart_enable;
  logic                  stop_enable;
  logic                  collision_flag;
  logic                  done_flag;
  logic                  cmd_tgl;
  logic                  cmd_is_stop;
  logic [COUNT_WIDTH-1:0] cmd_reload;
  logic                  evt_seen;
  logic                  evt_sync;
  logic                  evt_edge;
  logic [1:0]            lines_a;
  logic                  do_write;
  logic                  wr_control;
  logic                  wr_status;

  // ----------------------------------------------------------------
  // link side state (link_clk)
  // ----------------------------------------------------------------
  ics_state_e             state;
  logic [COUNT_WIDTH-1:0] baud_counter;
  logic [COUNT_WIDTH-1:0] lnk_reload;
  logic                   lnk_rst_n;
  logic                   cmd_sync;
  logic                   cmd_seen;
  logic                   cmd_edge;
  logic                   lnk_stop;
  logic                   evt_tgl;
  logic                   evt_coll;
  logic                   scl_s;
  logic                   sda_s;
  logic                   cnt_zero;
  logic                   go_collide;
  logic                   go_done;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data taken in either order, answer once both are held
  assign do_write = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        wr_data  <= wdata;
        wr_lane0 <= wstrb[0];
      end
      if (do_write) begin
        bvalid <= 1'b1;
        if (wr_addr == ADDR_WIDTH'(ADDR_CONTROL) || wr_addr == ADDR_WIDTH'(ADDR_RELOAD)
            || wr_addr == ADDR_WIDTH'(ADDR_STATUS)) begin
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // decoded write strobes; all registers live in byte lane 0
  assign wr_control = do_write && wr_lane0 && (wr_addr == ADDR_WIDTH'(ADDR_CONTROL));
  assign wr_status  = do_write && wr_lane0 && (wr_addr == ADDR_WIDTH'(ADDR_STATUS));

  // ----------------------------------------------------------------
  // baud reload register
  // ----------------------------------------------------------------
  // frozen while a sequence runs so the link copy stays coherent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_reload_register <= RELOAD_RESET;
    end else if (do_write && wr_lane0 && wr_addr == ADDR_WIDTH'(ADDR_RELOAD)
                 && !restart_enable && !stop_enable) begin
      baud_reload_register <= wr_data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // sequence enables and command launch
  // ----------------------------------------------------------------
  // launch only from idle; restart wins if both bits are written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_enable <= 1'b0;
      stop_enable    <= 1'b0;
      cmd_tgl        <= 1'b0;
      cmd_is_stop    <= 1'b0;
      cmd_reload     <= '0;
    end else if (evt_edge) begin
      restart_enable <= 1'b0;
      stop_enable    <= 1'b0;
    end else if (wr_control && !restart_enable && !stop_enable) begin
      if (wr_data[CTRL_RESTART_BIT]) begin
        restart_enable <= 1'b1;
        cmd_is_stop    <= 1'b0;
        cmd_reload     <= baud_reload_register[COUNT_WIDTH-1:0];
        cmd_tgl        <= !cmd_tgl;
      end else if (wr_data[CTRL_STOP_BIT]) begin
        stop_enable <= 1'b1;
        cmd_is_stop <= 1'b1;
        cmd_reload  <= baud_reload_register[COUNT_WIDTH-1:0];
        cmd_tgl     <= !cmd_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // completion events back from the link
  // ----------------------------------------------------------------
  ics_sync #(.WIDTH(1)) u_evt_sync (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     (evt_tgl),
    .q     (evt_sync)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_seen <= 1'b0;
    end else begin
      evt_seen <= evt_sync;
    end
  end

  assign evt_edge = evt_sync ^ evt_seen;

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      collision_flag <= 1'b0;
    end else if (evt_edge && evt_coll) begin
      collision_flag <= 1'b1;
    end else if (wr_status && wr_data[STAT_COLL_BIT]) begin
      collision_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
    end else if (evt_edge && !evt_coll) begin
      done_flag <= 1'b1;
    end else if (wr_status && wr_data[STAT_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // line levels for the bus-free indication software polls
  ics_sync #(.WIDTH(2)) u_line_sync_a (
    .clk   (aclk),
    .rst_n (aresetn),
    .d     ({serial_clock_line_i, serial_data_line_i}),
    .q     (lines_a)
  );

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      rdata   <= '0;
      if (araddr == ADDR_WIDTH'(ADDR_CONTROL)) begin
        rdata[CTRL_RESTART_BIT] <= restart_enable;
        rdata[CTRL_STOP_BIT]    <= stop_enable;
      end else if (araddr == ADDR_WIDTH'(ADDR_RELOAD)) begin
        rdata[7:0] <= baud_reload_register;
      end else if (araddr == ADDR_WIDTH'(ADDR_STATUS)) begin
        rdata[STAT_COLL_BIT] <= collision_flag;
        rdata[STAT_BUSY_BIT] <= restart_enable || stop_enable;
        rdata[STAT_DONE_BIT] <= done_flag;
        rdata[STAT_FREE_BIT] <= &lines_a;
      end else begin
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // link domain reset and crossings
  // ----------------------------------------------------------------
  // reset released into the link domain through its own two flops
  ics_sync #(.WIDTH(1)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (aresetn),
    .q     (lnk_rst_n)
  );

  ics_sync #(.WIDTH(1)) u_cmd_sync (
    .clk   (link_clk),
    .rst_n (lnk_rst_n),
    .d     (cmd_tgl),
    .q     (cmd_sync)
  );

  ics_sync #(.WIDTH(2)) u_line_sync_l (
    .clk   (link_clk),
    .rst_n (lnk_rst_n),
    .d     ({serial_clock_line_i, serial_data_line_i}),
    .q     ({scl_s, sda_s})
  );

  always_ff @(posedge link_clk) begin
    if (!lnk_rst_n) begin
      cmd_seen <= 1'b0;
    end else begin
      cmd_seen <= cmd_sync;
    end
  end

  // cmd_reload and cmd_is_stop are held until the event returns
  assign cmd_edge = cmd_sync ^ cmd_seen;
  assign cnt_zero = (baud_counter == '0);

  // ----------------------------------------------------------------
  // sequence decisions
  // ----------------------------------------------------------------
  always_comb begin
    go_collide = 1'b0;
    go_done    = 1'b0;
    case (state)
      ICS_RS_CLK_WAIT: go_collide = scl_s && !sda_s;
      ICS_RS_COUNT2:   go_collide = !scl_s && !serial_data_line_oe;
      ICS_RS_COUNT3:   go_done    = cnt_zero;
      ICS_SP_COUNT1:   go_collide = !scl_s;
      ICS_SP_COUNT2: begin
        go_collide = (!scl_s && !sda_s) || (cnt_zero && !sda_s);
        go_done    = cnt_zero && sda_s;
      end
      default: begin
        go_collide = 1'b0;
        go_done    = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer state, baud counter and line drive
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (!lnk_rst_n) begin
      state                <= ICS_IDLE;
      baud_counter         <= '0;
      lnk_reload           <= '0;
      lnk_stop             <= 1'b0;
      serial_clock_line_oe <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      evt_tgl              <= 1'b0;
      evt_coll             <= 1'b0;
    end else if (go_collide) begin
      state                <= ICS_IDLE;
      serial_clock_line_oe <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      evt_coll             <= 1'b1;
      evt_tgl              <= !evt_tgl;
    end else if (go_done) begin
      state                <= ICS_IDLE;
      serial_clock_line_oe <= !lnk_stop;
      evt_coll             <= 1'b0;
      evt_tgl              <= !evt_tgl;
    end else begin
      if (!cnt_zero) begin
        baud_counter <= baud_counter - 1'b1;
      end
      case (state)
        ICS_IDLE: begin
          if (cmd_edge) begin
            lnk_reload           <= cmd_reload;
            lnk_stop             <= cmd_is_stop;
            serial_clock_line_oe <= 1'b1;
            serial_data_line_oe  <= cmd_is_stop;
            state <= cmd_is_stop ? ICS_SP_DATA_LOW : ICS_RS_REL_DATA;
          end
        end
        // clock held low while data floats up
        ICS_RS_REL_DATA: begin
          if (sda_s) begin
            baud_counter <= lnk_reload;
            state        <= ICS_RS_COUNT1;
          end
        end
        ICS_RS_COUNT1: begin
          if (cnt_zero) begin
            serial_clock_line_oe <= 1'b0;
            state                <= ICS_RS_CLK_WAIT;
          end
        end
        // other masters may stretch the clock here
        ICS_RS_CLK_WAIT: begin
          if (scl_s) begin
            baud_counter <= lnk_reload;
            state        <= ICS_RS_COUNT2;
          end
        end
        // a data fall now is another start, not a collision
        ICS_RS_COUNT2: begin
          if (cnt_zero) begin
            serial_data_line_oe <= 1'b1;
            baud_counter        <= lnk_reload;
            state               <= ICS_RS_COUNT3;
          end
        end
        ICS_SP_DATA_LOW: begin
          if (!sda_s) begin
            serial_clock_line_oe <= 1'b0;
            state                <= ICS_SP_CLK_WAIT;
          end
        end
        ICS_SP_CLK_WAIT: begin
          if (scl_s) begin
            baud_counter <= lnk_reload;
            state        <= ICS_SP_COUNT1;
          end
        end
        ICS_SP_COUNT1: begin
          if (cnt_zero) begin
            serial_data_line_oe <= 1'b0;
            baud_counter        <= lnk_reload;
            state               <= ICS_SP_COUNT2;
          end
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // open-drain output levels
  // ----------------------------------------------------------------
  // the lines are only ever pulled low; release means enable off
  always_ff @(posedge link_clk) begin
    if (!lnk_rst_n) begin
      serial_clock_line_o <= 1'b0;
      serial_data_line_o  <= 1'b0;
    end else begin
      serial_clock_line_o <= 1'b0;
      serial_data_line_o  <= 1'b0;
    end
  end

endmodule

// ==== tb/ics_props.sv ====
// bus handshake and line-order checks for the restart/stop sequencer
`timescale 1ns/1ps
module ics_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic [1:0] bresp,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [1:0] rresp,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic       link_clk,
  input wire logic       serial_clock_line_i,
  input wire logic       serial_clock_line_oe,
  input wire logic       serial_data_line_i,
  input wire logic       serial_data_line_oe
);
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rresp)) else $error("read answer dropped");
  AST_R_TURN: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid) else $error("read answer late");
  AST_B_TURN: assert property (@(posedge aclk) disable iff (!aresetn)
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid) else $error("write answer off");
  AST_B_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> !awready && !wready) else $error("write taken while answering");
  // ----------------------------------------------------------------
  // line order; sampled levels trail the wire by two link cycles
  // ----------------------------------------------------------------
  AST_RS_DATA_FIRST: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(serial_clock_line_oe) && !serial_data_line_oe |-> $past(serial_data_line_i, 2))
    else $error("clock released before data high");
  AST_SP_DATA_FIRST: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(serial_clock_line_oe) && serial_data_line_oe |-> !$past(serial_data_line_i, 2))
    else $error("clock released before data low");
  AST_RS_CLK_HIGH: assert property (@(posedge link_clk) disable iff (!aresetn)
    $rose(serial_data_line_oe) && !serial_clock_line_oe |-> $past(serial_clock_line_i, 2))
    else $error("data driven while clock low");
  AST_RS_CLK_DRIVE: assert property (@(posedge link_clk) disable iff (!aresetn)
    $rose(serial_data_line_oe) && !serial_clock_line_oe |-> ##[1:130] serial_clock_line_oe)
    else $error("clock not driven after second count");
endmodule

bind ics_top ics_props chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .link_clk(link_clk), .serial_clock_line_i(serial_clock_line_i),
  .serial_clock_line_oe(serial_clock_line_oe), .serial_data_line_i(serial_data_line_i),
  .serial_data_line_oe(serial_data_line_oe)
);

// ==== tb/ics_far_end.sv ====
// another bus party that can stretch the clock or pull the data line low
`timescale 1ns/1ps
module ics_far_end (
  input  wire logic link_clk,
  input  wire logic hold_clock,
  input  wire logic hold_data,
  output logic      far_clk_oe,
  output logic      far_dat_oe
);
  // clock stretch: slow answers come from holding the clock line
  always_ff @(posedge link_clk) begin
    far_clk_oe <= hold_clock;
  end
  // data pull: another master claiming or contesting the data line
  always_ff @(posedge link_clk) begin
    far_dat_oe <= hold_data;
  end
endmodule

// ==== tb/ics_top_bench.sv ====
// self-checking bench: register tasks, far-end model and restart/stop scenarios
`timescale 1ns/1ps
module ics_top_bench;
  import ics_pkg::*;
  logic        aclk, aresetn, link_clk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, hold_clock, hold_data, cnt_clr;
  logic        clk_o, clk_oe, dat_o, dat_oe, far_clk_oe, far_dat_oe, clk_line, dat_line;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          fails, n_compared, cycles, rs_cnt;

  // wired-and lines with pull-ups
  assign clk_line = (clk_oe === 1'h1 || far_clk_oe === 1'h1) ? 1'h0 : 1'h1;
  assign dat_line = (dat_oe === 1'h1 || far_dat_oe === 1'h1) ? 1'h0 : 1'h1;

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  // link clock offset so its edges never line up with the bus clock
  initial begin
    link_clk = 1'h0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  ics_top #(.ADDR_WIDTH(8)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link_clk(link_clk),
    .serial_clock_line_i(clk_line), .serial_clock_line_o(clk_o), .serial_clock_line_oe(clk_oe),
    .serial_data_line_i(dat_line), .serial_data_line_o(dat_o), .serial_data_line_oe(dat_oe)
  );
  ics_far_end far (
    .link_clk(link_clk), .hold_clock(hold_clock), .hold_data(hold_data),
    .far_clk_oe(far_clk_oe), .far_dat_oe(far_dat_oe)
  );

  // cycles with data driven and clock released: second restart count
  always @(posedge link_clk) begin
    if (cnt_clr) rs_cnt <= 0;
    else if (dat_oe === 1'h1 && clk_oe === 1'h0) rs_cnt <= rs_cnt + 1;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    cmp("write response", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd_raw(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd_val = rdata;
    rsp = rresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd_raw(a);
    cmp("read response", {30'h0, RESP_OKAY}, {30'h0, rsp});
    cmp(what, exp, rd_val);
  endtask

  // poll status until any bit of mask is set
  task automatic wait_bits(input logic [31:0] mask);
    int k;
    k = 0;
    do begin
      rd_raw(ADDR_STATUS);
      k++;
    end while ((rd_val & mask) === 32'h0 && k < 300);
    cmp("status wait", 32'h1, {31'h0, (rd_val & mask) !== 32'h0});
  endtask

  task automatic far_set(input logic c, input logic d);
    @(posedge aclk);
    hold_clock <= c;
    hold_data <= d;
  endtask

  // waits until the device has driven and then released the clock line
  task automatic wait_clk_free();
    int k;
    for (k = 0; k < 400 && clk_oe !== 1'h1; k++) @(posedge aclk);
    cmp("clock driven", 32'h1, {31'h0, k < 400});
    for (k = 0; k < 400 && clk_oe !== 1'h0; k++) @(posedge aclk);
    cmp("clock released", 32'h1, {31'h0, k < 400});
  endtask

  // one collision per kind: restart data low, restart clock low, stop data, stop clock
  task automatic collide(input int kind);
    if (kind == 2) far_set(1'h0, 1'h1);
    if (kind == 0) far_set(1'h1, 1'h0);
    wr(ADDR_CONTROL, (kind < 2) ? 32'h1 : 32'h2, RESP_OKAY);
    if (kind != 2) wait_clk_free();
    if (kind == 0) begin
      far_set(1'h1, 1'h1);
      repeat (4) @(posedge link_clk);
      far_set(1'h0, 1'h1);
    end
    if (kind == 1 || kind == 3) begin
      repeat (6) @(posedge link_clk);
      far_set(1'h1, 1'h0);
    end
    wait_bits(32'h5);
    cmp("status after collision", 32'h1, rd_val);
    cmp("device line drive", 32'h0, {30'h0, clk_oe, dat_oe});
    rd(ADDR_CONTROL, 32'h0, "enables after collision");
    far_set(1'h0, 1'h0);
    wait_bits(32'h8);
    wr(ADDR_STATUS, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h8, "status cleared");
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hold_clock, hold_data} = 8'h00;
    {awaddr, araddr, wdata, cnt_clr} = 49'h0;
    wstrb = 4'hF;
    {fails, n_compared, cycles} = 96'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge link_clk);
    rd(ADDR_RELOAD, {24'h0, RELOAD_RESET}, "reload reset");
    rd(ADDR_STATUS, 32'h8, "status reset");
    rd_raw(8'h0C);
    cmp("unmapped read response", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(8'h0C, 32'hFF, RESP_SLVERR);
    wr(ADDR_RELOAD, 32'hFFFF_FF20, RESP_OKAY);
    rd(ADDR_RELOAD, 32'h20, "reload upper bits");
    // clean restart; writes during it must be dropped
    cnt_clr <= 1'h1;
    repeat (2) @(posedge link_clk);
    @(posedge aclk);
    cnt_clr <= 1'h0;
    wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
    wr(ADDR_CONTROL, 32'h2, RESP_OKAY);
    wr(ADDR_RELOAD, 32'h7F, RESP_OKAY);
    wait_bits(32'h5);
    cmp("restart status", 32'h4, rd_val);
    rd(ADDR_CONTROL, 32'h0, "restart enable cleared");
    rd(ADDR_RELOAD, 32'h20, "reload while busy");
    cmp("second count length", 32'h21, rs_cnt);
    cmp("lines after restart", 32'h0, {30'h0, clk_line, dat_line});
    cmp("open-drain levels", 32'h0, {30'h0, clk_o, dat_o});
    wr(ADDR_STATUS, 32'h4, RESP_OKAY);
    // repeated restart; another master pulls data in the recount before data drive
    wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
    wait_clk_free();
    repeat (6) @(posedge link_clk);
    far_set(1'h0, 1'h1);
    wait_bits(32'h5);
    cmp("restart with data fall", 32'h4, rd_val);
    far_set(1'h0, 1'h0);
    wr(ADDR_STATUS, 32'h4, RESP_OKAY);
    // clean stop from the held-clock state
    wr(ADDR_CONTROL, 32'h2, RESP_OKAY);
    wait_bits(32'h5);
    cmp("stop status", 32'hC, rd_val);
    cmp("lines after stop", 32'h3, {30'h0, clk_line, dat_line});
    wr(ADDR_STATUS, 32'h4, RESP_OKAY);
    for (int k = 0; k < 4; k++) collide(k);
    summarize();
  end
endmodule
